// ==== hdl/ccs_crc_walk.sv ====
// Serial CRC walker over the non-volatile image for the self test
`timescale 1ns/1ps
module ccs_crc_walk #(
  parameter int WORDS = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic fail,
  output logic done,
  // Non-volatile image access
  output logic [7:0] nv_addr,
  input wire logic [7:0] nv_data,
  input wire logic [7:0] nv_crc_ref
);
  if (WORDS < 1 || WORDS > 256) begin : g_chk
    $error("ccs_crc_walk: WORDS out of range");
  end

  logic [7:0] crc_r;
  logic [7:0] crc_nxt;
  logic [7:0] cnt_r;

  // Byte-wide CRC step, MSB first
  always_comb begin
    logic [7:0] c;
    c = crc_r ^ nv_data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ ccs_pkg::CRC_POLY) : (c << 1);
    end
    crc_nxt = c;
  end

  assign nv_addr = cnt_r;

  // Walk the image one byte per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      fail <= 1'b0;
      done <= 1'b0;
      crc_r <= ccs_pkg::CRC_INIT;
      cnt_r <= 8'h00;
    end else begin
      done <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1;
        crc_r <= ccs_pkg::CRC_INIT;
        cnt_r <= 8'h00;
      end else if (busy) begin
        crc_r <= crc_nxt;
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == 8'(WORDS - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
          fail <= (crc_nxt != nv_crc_ref);
        end
      end
    end
  end
endmodule : ccs_crc_walk

// ==== hdl/ccs_pkg.sv ====
// Package of constants and carrier types for the common command and status unit
package ccs_pkg;

  // ==========================================================
  // Command codes
  typedef enum logic [3:0] {
    CCS_CMD_CLS, CCS_CMD_ESE, CCS_CMD_ESR_Q, CCS_CMD_IDN_Q, CCS_CMD_OPC, CCS_CMD_OPC_Q,
    CCS_CMD_RCL, CCS_CMD_RST, CCS_CMD_SAV, CCS_CMD_SRE, CCS_CMD_STB_Q, CCS_CMD_TRG,
    CCS_CMD_TST_Q, CCS_CMD_ESE_Q, CCS_CMD_SRE_Q, CCS_CMD_BAD
  } ccs_cmd_type;

  // ==========================================================
  // Status byte bit positions
  localparam int SB_OPER = 7;
  localparam int SB_RQS = 6;
  localparam int SB_ESB = 5;
  localparam int SB_MAV = 4;
  localparam int SB_QUES = 3;
  localparam int SB_ERRQ = 2;

  // Event status bit positions
  localparam int ES_PON = 7;
  localparam int ES_CME = 5;
  localparam int ES_EXE = 4;
  localparam int ES_DDE = 3;
  localparam int ES_QYE = 2;
  localparam int ES_OPC = 0;

  // Writable bits of the service request mask (bit 6 cannot be set)
  localparam logic [7:0] SRE_WMASK = 8'hBF;
  // Mask and enable reset values
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] ESE_RST = 8'h00;

  // Memory slots
  localparam int SLOT_MIN = 1;
  localparam int SLOT_MAX = 40;

  // Output level width and reset values
  localparam int LVL_W = 16;
  localparam logic [15:0] LVL_ZERO = 16'h0000;
  localparam logic [15:0] LVL_MAX = 16'hFFFF;

  // Reply characters
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_COMMA = 8'h2C;
  localparam logic [7:0] CH_DOT = 8'h2E;

  // CRC-8 polynomial for the memory check
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;

  // Output settings carried between save, recall and reset
  typedef struct packed {
    logic [15:0] curr;
    logic [15:0] volt;
    logic [15:0] ocp;
    logic [15:0] ovp;
    logic outp_on;
    logic lang;
  } ccs_setting_type;

  // Command carrier
  typedef struct packed {
    ccs_cmd_type code;
    logic [7:0] arg;
  } ccs_req_type;

endpackage : ccs_pkg

// ==== hdl/ccs_slot_mem.sv ====
// Storage of the forty saved output setting slots
`timescale 1ns/1ps
module ccs_slot_mem #(
  parameter int SLOTS = 40
) (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [5:0] wr_idx,
  input wire ccs_pkg::ccs_setting_type wr_data,
  // Read side, one cycle latency
  input wire logic [5:0] rd_idx,
  output ccs_pkg::ccs_setting_type rd_data
);
  // Elaboration check on depth
  if (SLOTS < 1 || SLOTS > 64) begin : g_chk
    $error("ccs_slot_mem: SLOTS out of range");
  end

  // Slot array
  ccs_pkg::ccs_setting_type mem [SLOTS];

  // Synchronous write and registered read
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    rd_data <= mem[rd_idx];
  end
endmodule : ccs_slot_mem

// ==== hdl/ccs_unit.sv ====
// Common command and status unit of the instrument bus interface
// ==========================================================
// Overview of operation
// - OPC sets event bit 0 once idle
// - OPC query stalls later commands, queues one
// - Recall reloads levels and limits, slots 1-40
// - Save stores levels, limits, output, language
// - Reset: levels zero, limits max, output on
// - Service mask 0-255, bit 6 ignored
// - Enabled status bits ORed into bit 6
// - Serial poll clears request; summary not cleared
// - Status byte bit layout, bits 1,0 zero
// - Status byte query clears nothing
// - Serial poll returns request bit, then clears
// - Armed trigger applies pending levels, disarms
// - Continuous initiation re-arms after trigger
// - Trigger acts only when addressed listener
// - Self test CRC: 0 pass, 1 fail
// - Identification: four comma separated fields
// - Event register read clears it
// - Unknown command sets bit 5
// - Power-on bit set until read/cleared
// - Event status bit layout
// - Enabled event bits set summary bit 5
// - Clear status keeps enable masks
`timescale 1ns/1ps
module ccs_unit #(
  parameter int SLOTS = 40,
  parameter int NV_WORDS = 16,
  parameter logic [7:0] MFR_CH = 8'h58,  // Arbitrary maker letter
  parameter logic [7:0] MODEL_CH = 8'h4D,  // Arbitrary model letter
  parameter logic [7:0] DATA_CH = 8'h44,  // Arbitrary manufacturing data letter
  parameter logic [7:0] FW_MAJ = 8'h31,
  parameter logic [7:0] FW_MIN = 8'h30
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Parsed command input
  input wire logic cmd_valid,
  input wire ccs_pkg::ccs_req_type cmd,
  output logic cmd_ready,
  // Bus state
  input wire logic listen_addr,
  input wire logic get_msg,
  input wire logic spoll,
  // Output queue byte stream
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_take,
  // Status sources
  input wire logic oper_sum,
  input wire logic ques_sum,
  input wire logic err_pending,
  input wire logic exe_err,
  input wire logic dde_err,
  input wire logic qye_err,
  input wire logic out_settled,
  input wire logic init_cont,
  input wire logic init_arm,
  input wire ccs_pkg::ccs_setting_type trig_lvl,
  output logic clr_status,
  // Non-volatile image
  output logic [7:0] nv_addr,
  input wire logic [7:0] nv_data,
  input wire logic [7:0] nv_crc_ref,
  // Outputs
  output ccs_pkg::ccs_setting_type setting,
  output logic trigger_armed_flag,
  output logic [7:0] status_summary_byte,
  output logic [7:0] service_request_mask,
  output logic srq
);
  if (SLOTS != ccs_pkg::SLOT_MAX) begin : g_chk
    $error("ccs_unit: SLOTS must equal forty");
  end

  // ==========================================================
  // State
  typedef enum logic [2:0] {ST_IDLE, ST_OPCQ, ST_RCL, ST_TST, ST_IDN} ccs_st_type;
  ccs_st_type st_r;
  logic [7:0] esr_r;  // Standard event status
  logic [7:0] ese_r;  // Event enable mask
  logic [7:0] sre_r;  // Service request mask
  logic rqs_r;  // Request for service latch
  logic opc_pend_r;  // OPC waiting for idle
  logic [7:0] q_r [16];  // Reply string buffer
  logic [3:0] q_len_r;
  logic [3:0] q_pos_r;
  logic [7:0] sb_r;
  logic srq_r;
  ccs_pkg::ccs_setting_type set_r;
  logic armed_r;
  ccs_pkg::ccs_setting_type mem_rd;
  logic tst_busy, tst_fail, tst_done;

  // ==========================================================
  // Decode
  wire take = cmd_valid && cmd_ready;
  wire ccs_pkg::ccs_cmd_type code = cmd.code;
  wire slot_ok = (cmd.arg >= 8'(ccs_pkg::SLOT_MIN)) && (cmd.arg <= 8'(ccs_pkg::SLOT_MAX));
  wire [5:0] slot_idx = 6'(cmd.arg - 8'h01);
  wire esr_read = take && code == ccs_pkg::CCS_CMD_ESR_Q;
  wire cls = take && code == ccs_pkg::CCS_CMD_CLS;
  wire mav = (q_len_r != 4'h0);
  wire quiet = out_settled && !cmd_valid;
  wire bus_trg = listen_addr && (get_msg || (take && code == ccs_pkg::CCS_CMD_TRG));
  wire fire = bus_trg && armed_r;
  wire esb = |(esr_r & ese_r);
  wire [7:0] sb_low = {oper_sum, 1'b0, esb, mav, ques_sum, err_pending, 2'b00};
  wire mss = |(sb_low & sre_r);
  wire opc_set = opc_pend_r && quiet && st_r == ST_IDLE;
  wire [7:0] esr_ev = {1'b0, 1'b0, take && code == ccs_pkg::CCS_CMD_BAD, exe_err, dde_err,
                       qye_err, 1'b0, opc_set};

  // Slot memory
  ccs_slot_mem #(.SLOTS(SLOTS)) u_mem (
    .clk(clk),
    .wr_en(take && code == ccs_pkg::CCS_CMD_SAV && slot_ok),
    .wr_idx(slot_idx),
    .wr_data(set_r),
    .rd_idx(slot_idx),
    .rd_data(mem_rd)
  );

  // CRC self test
  ccs_crc_walk #(.WORDS(NV_WORDS)) u_crc (
    .clk(clk),
    .rst(rst),
    .start(take && code == ccs_pkg::CCS_CMD_TST_Q),
    .busy(tst_busy),
    .fail(tst_fail),
    .done(tst_done),
    .nv_addr(nv_addr),
    .nv_data(nv_data),
    .nv_crc_ref(nv_crc_ref)
  );

  // ==========================================================
  // Event and mask registers
  always_ff @(posedge clk) begin
    if (rst) begin
      esr_r <= 8'h80;
      ese_r <= ccs_pkg::ESE_RST;
      sre_r <= ccs_pkg::SRE_RST;
      opc_pend_r <= 1'b0;
    end else begin
      // Read or clear first, new events win
      esr_r <= ((esr_read || cls) ? 8'h00 : esr_r) | esr_ev;
      if (take && code == ccs_pkg::CCS_CMD_ESE) begin
        ese_r <= cmd.arg;
      end
      if (take && code == ccs_pkg::CCS_CMD_SRE) begin
        sre_r <= cmd.arg & ccs_pkg::SRE_WMASK;
      end
      if (take && code == ccs_pkg::CCS_CMD_OPC) begin
        opc_pend_r <= 1'b1;
      end else if (opc_set) begin
        opc_pend_r <= 1'b0;
      end
    end
  end

  // Status byte and request for service
  always_ff @(posedge clk) begin
    if (rst) begin
      sb_r <= 8'h00;
      rqs_r <= 1'b0;
      srq_r <= 1'b0;
      status_summary_byte <= 8'h00;
    end else begin
      sb_r <= sb_low | {1'b0, mss, 6'h00};
      // Rising summary raises request; a poll clears it
      if (mss && !sb_r[ccs_pkg::SB_RQS]) begin
        rqs_r <= 1'b1;
      end else if (spoll) begin
        rqs_r <= 1'b0;
      end
      srq_r <= rqs_r;
      // A poll shows the request latch before it clears
      status_summary_byte <= sb_low | {1'b0, spoll ? rqs_r : mss, 6'h00};
    end
  end

  // ==========================================================
  // Command sequencer, settings and reply queue
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= ST_IDLE;
      set_r <= '{ccs_pkg::LVL_ZERO, ccs_pkg::LVL_ZERO, ccs_pkg::LVL_MAX, ccs_pkg::LVL_MAX,
                 1'b1, 1'b0};
      armed_r <= 1'b0;
      q_len_r <= 4'h0;
      q_pos_r <= 4'h0;
      for (int i = 0; i < 16; i++) begin
        q_r[i] <= 8'h00;
      end
    end else begin
      // Drain reply
      if (mav && rsp_take) begin
        if (q_pos_r + 4'h1 == q_len_r) begin
          q_len_r <= 4'h0;
          q_pos_r <= 4'h0;
        end else begin
          q_pos_r <= q_pos_r + 4'h1;
        end
      end
      // Trigger arming
      if (fire) begin
        set_r.curr <= trig_lvl.curr;
        set_r.volt <= trig_lvl.volt;
        armed_r <= init_cont || init_arm;
      end else if (init_arm) begin
        armed_r <= 1'b1;
      end
      unique case (st_r)
        ST_IDLE: begin
          if (take) begin
            unique case (code)
              ccs_pkg::CCS_CMD_OPC_Q: st_r <= ST_OPCQ;
              ccs_pkg::CCS_CMD_RCL: st_r <= slot_ok ? ST_RCL : ST_IDLE;
              ccs_pkg::CCS_CMD_TST_Q: st_r <= ST_TST;
              ccs_pkg::CCS_CMD_IDN_Q: st_r <= ST_IDN;
              ccs_pkg::CCS_CMD_RST: begin
                set_r <= '{ccs_pkg::LVL_ZERO, ccs_pkg::LVL_ZERO, ccs_pkg::LVL_MAX,
                           ccs_pkg::LVL_MAX, 1'b1, set_r.lang};
              end
              ccs_pkg::CCS_CMD_ESR_Q: begin
                q_r[0] <= esr_r;
                q_len_r <= 4'h1;
              end
              ccs_pkg::CCS_CMD_STB_Q: begin
                q_r[0] <= sb_r;
                q_len_r <= 4'h1;
              end
              ccs_pkg::CCS_CMD_ESE_Q: begin
                q_r[0] <= ese_r;
                q_len_r <= 4'h1;
              end
              ccs_pkg::CCS_CMD_SRE_Q: begin
                q_r[0] <= sre_r;
                q_len_r <= 4'h1;
              end
              default: ;
            endcase
          end
        end
        // Wait for outputs to settle, then queue one
        ST_OPCQ: begin
          if (out_settled) begin
            q_r[0] <= ccs_pkg::CH_1;
            q_len_r <= 4'h1;
            st_r <= ST_IDLE;
          end
        end
        // Memory read data lands one cycle after take
        ST_RCL: begin
          set_r.curr <= mem_rd.curr;
          set_r.volt <= mem_rd.volt;
          set_r.ocp <= mem_rd.ocp;
          set_r.ovp <= mem_rd.ovp;
          st_r <= ST_IDLE;
        end
        ST_TST: begin
          if (tst_done) begin
            q_r[0] <= tst_fail ? ccs_pkg::CH_1 : ccs_pkg::CH_0;
            q_len_r <= 4'h1;
            st_r <= ST_IDLE;
          end
        end
        ST_IDN: begin
          q_r[0] <= MFR_CH;
          q_r[1] <= ccs_pkg::CH_COMMA;
          q_r[2] <= MODEL_CH;
          q_r[3] <= ccs_pkg::CH_COMMA;
          q_r[4] <= DATA_CH;
          q_r[5] <= ccs_pkg::CH_COMMA;
          q_r[6] <= FW_MAJ;
          q_r[7] <= ccs_pkg::CH_DOT;
          q_r[8] <= FW_MIN;
          q_len_r <= 4'h9;
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Registered outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      clr_status <= 1'b0;
      cmd_ready <= 1'b0;
    end else begin
      // Ready rests a cycle after each take, so a queued reply blocks in time
      cmd_ready <= (st_r == ST_IDLE) && !mav && !take;
      rsp_valid <= mav && !(rsp_take && q_pos_r + 4'h1 == q_len_r);
      rsp_data <= q_r[4'(q_pos_r + ((mav && rsp_take) ? 4'h1 : 4'h0))];
      clr_status <= cls;
    end
  end

  assign setting = set_r;
  assign trigger_armed_flag = armed_r;
  assign service_request_mask = sre_r;
  assign srq = srq_r;

  // ==========================================================
  // Assertions
  AST_SRE_BIT6: assert property (@(posedge clk) disable iff (rst)
    !sre_r[6]) else $error("mask bit 6 set");
  AST_ESR_CLEAR: assert property (@(posedge clk) disable iff (rst)
    esr_read |=> ((esr_r & 8'hDE) == ($past(esr_ev) & 8'hDE))) else $error("esr not cleared");
  AST_BAD_CME: assert property (@(posedge clk) disable iff (rst)
    (take && code == ccs_pkg::CCS_CMD_BAD) |=> esr_r[5]) else $error("cme missing");
  AST_MSS: assert property (@(posedge clk) disable iff (rst)
    ##1 sb_r[6] == $past(mss)) else $error("mss wrong");
  AST_ESB: assert property (@(posedge clk) disable iff (rst)
    ##1 sb_r[5] == $past(esb)) else $error("esb wrong");
  AST_TRG: assert property (@(posedge clk) disable iff (rst)
    fire |=> (set_r.volt == $past(trig_lvl.volt)) &&
    armed_r == ($past(init_cont) || $past(init_arm)))
    else $error("trigger wrong");
  AST_NOLISTEN: assert property (@(posedge clk) disable iff (rst)
    (!listen_addr && armed_r) |=> armed_r) else $error("trigger taken off bus");
  AST_OPCQ_HOLD: assert property (@(posedge clk) disable iff (rst)
    st_r == ST_OPCQ |-> !cmd_ready) else $error("opc query not holding");
  AST_RST_LVL: assert property (@(posedge clk) disable iff (rst)
    (take && code == ccs_pkg::CCS_CMD_RST) |=> set_r.curr == 16'h0000 && set_r.outp_on)
    else $error("reset levels");
  COV_TRG: cover property (@(posedge clk) fire);
  COV_OPCQ: cover property (@(posedge clk) st_r == ST_OPCQ ##1 st_r == ST_IDLE);
  COV_TST: cover property (@(posedge clk) tst_done);
endmodule : ccs_unit

// ==== sim/ccs_ctrl_model.sv ====
// Bus controller model that drains reply bytes from the unit
`timescale 1ns/1ps
module ccs_ctrl_model (
  // Clock
  input wire logic clk,
  // Reply stream
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  output logic rsp_take,
  // Holds off reading while high
  input wire logic stall
);
  // Bytes received, read by the bench
  logic [7:0] rx_q[$];
  // ==========================================================
  // Take pulse: one cycle high, one low, only on an offered byte
  initial rsp_take = 1'b0;
  always @(negedge clk) begin
    if (rsp_take) begin
      rsp_take <= 1'b0;
    end else if (rsp_valid && !stall) begin
      rsp_take <= 1'b1;
    end
  end
  // Capture at the edge where the byte is taken
  always @(posedge clk) begin
    if (rsp_take && rsp_valid) begin
      rx_q.push_back(rsp_data);
    end
  end
endmodule : ccs_ctrl_model

// ==== sim/tb.sv ====
// Self-checking bench of the common command and status unit
`timescale 1ns/1ps
module tb;
  localparam int NVW = 4; // Short memory image keeps the test quick
  // ==========================================================
  // Stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cmd_valid = 1'b0;
  ccs_pkg::ccs_req_type cmd = '0;
  logic listen_addr = 1'b1, get_msg = 1'b0, spoll = 1'b0, stall = 1'b0;
  logic oper_sum = 1'b0, ques_sum = 1'b0, err_pending = 1'b0;
  logic exe_err = 1'b0, dde_err = 1'b0, qye_err = 1'b0;
  logic out_settled = 1'b1, init_cont = 1'b0, init_arm = 1'b0;
  ccs_pkg::ccs_setting_type trig_lvl = '0;
  logic [7:0] nv_crc_ref = 8'h00;
  logic [7:0] nv_img [0:255]; // Memory image seen by the self test
  // Design outputs
  logic cmd_ready, rsp_valid, rsp_take, clr_status, trigger_armed_flag, srq;
  logic [7:0] rsp_data, nv_addr, status_summary_byte, service_request_mask;
  ccs_pkg::ccs_setting_type setting;
  wire logic [7:0] nv_data;
  // Bench model state
  int fail_count = 0;
  int check_count = 0;
  int esr = 8'h80, sre_m = 0, ese_m = 0, clr_seen = 0;
  logic [63:0] lv_m; // Levels and limits expected
  logic [63:0] slot_m [1:40];
  logic [7:0] b, v;
  logic [7:0] idn [9];
  int sl [4] = '{1, 40, 0, 41};
  int rc [4] = '{0, 1, 41, 40};
  assign nv_data = nv_img[nv_addr];
  always #50 clk = ~clk;
  always @(posedge clk) if (clr_status === 1'b1) clr_seen++;
  // ==========================================================
  // Unit and controller model; identity letters are arbitrary
  ccs_unit #(.NV_WORDS(NVW), .MFR_CH(8'h51), .MODEL_CH(8'h5A),
    .DATA_CH(8'h37), .FW_MAJ(8'h32)) dut (.clk, .rst, .cmd_valid,
    .cmd, .cmd_ready, .listen_addr, .get_msg, .spoll, .rsp_valid, .rsp_data,
    .rsp_take, .oper_sum, .ques_sum, .err_pending, .exe_err, .dde_err, .qye_err,
    .out_settled, .init_cont, .init_arm, .trig_lvl, .clr_status, .nv_addr,
    .nv_data, .nv_crc_ref, .setting, .trigger_armed_flag, .status_summary_byte,
    .service_request_mask, .srq);
  ccs_ctrl_model ctl (.clk, .rsp_valid, .rsp_data, .rsp_take, .stall);
  // ==========================================================
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : chk
  // Command held until a ready edge takes it
  task automatic send(input ccs_pkg::ccs_cmd_type c, input logic [7:0] a);
    int n;
    n = 0;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = '{code: c, arg: a};
    while (cmd_ready !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    cmd_valid = 1'b0;
    if (n >= 300) fail_count++;
  endtask : send
  // Next reply byte, bounded wait
  task automatic get(output logic [7:0] d);
    int n;
    n = 0;
    while (ctl.rx_q.size() == 0 && n < 300) begin
      @(negedge clk);
      n++;
    end
    d = (ctl.rx_q.size() > 0) ? ctl.rx_q.pop_front() : 8'hXX;
  endtask : get
  // Single byte query
  task automatic q1(input ccs_pkg::ccs_cmd_type c, input logic [7:0] e);
    logic [7:0] d;
    send(c, 8'h00);
    get(d);
    chk(64'(d), 64'(e));
  endtask : q1
  // Expected status byte from the model
  function automatic logic [7:0] stb_m(input logic mav);
    logic [7:0] s;
    s = {oper_sum, 1'b0, |(esr[7:0] & ese_m[7:0]), mav, ques_sum, err_pending, 2'b00};
    s[6] = |(s & sre_m[7:0]);
    return s;
  endfunction : stb_m
  // CRC-8 of the image, MSB first
  function automatic logic [7:0] crc_m();
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < NVW; i++) begin
      c ^= nv_img[i];
      repeat (8) c = c[7] ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_m
  // Arm, then trigger by command or by group trigger
  task automatic trg(input logic ln, input logic gm);
    @(negedge clk);
    trig_lvl = {16'($urandom), 16'($urandom), lv_m[31:0], 2'b10};
    init_arm = 1'b1;
    @(negedge clk);
    init_arm = 1'b0;
    listen_addr = ln;
    chk(64'(trigger_armed_flag), 64'h1);
    if (gm) begin
      get_msg = 1'b1;
      @(negedge clk);
      get_msg = 1'b0;
    end else begin
      send(ccs_pkg::CCS_CMD_TRG, 8'h00);
    end
    repeat (2) @(negedge clk);
    if (ln) lv_m[63:32] = trig_lvl[65:34];
    listen_addr = 1'b1;
    chk(setting[65:2], lv_m);
    chk(64'(trigger_armed_flag), 64'(!ln || init_cont));
  endtask : trg
  // Verdict and end of run
  task automatic print_verdict();
    $display("checks=%0d errors=%0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  // Watchdog well past the expected run length
  initial begin
    #2000000;
    fail_count++;
    print_verdict();
  end
  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(32'hD34C2489));
    for (int i = 0; i < 256; i++) nv_img[i] = 8'($urandom);
    lv_m = {ccs_pkg::LVL_ZERO, ccs_pkg::LVL_ZERO, ccs_pkg::LVL_MAX, ccs_pkg::LVL_MAX};
    idn = '{8'h51, 8'h2C, 8'h5A, 8'h2C, 8'h37, 8'h2C, 8'h32, 8'h2E, 8'h30};
    repeat (5) @(negedge clk);
    rst = 1'b0;
    chk(setting[65:2], lv_m);
    chk(64'(setting.outp_on), 64'h1);
    chk(64'(status_summary_byte), 64'(stb_m(1'b0)));
    q1(ccs_pkg::CCS_CMD_ESR_Q, 8'h80);
    esr = 0;
    q1(ccs_pkg::CCS_CMD_ESR_Q, 8'h00);
    // Service mask, bit 6 never sticks, top value last
    for (int i = 0; i < 4; i++) begin
      v = (i == 3) ? 8'hFF : 8'($urandom);
      send(ccs_pkg::CCS_CMD_SRE, v);
      sre_m = v & 8'hBF;
      q1(ccs_pkg::CCS_CMD_SRE_Q, 8'(sre_m));
      chk(64'(service_request_mask), 64'(sre_m));
    end
    // Event bits, summaries and request for service
    send(ccs_pkg::CCS_CMD_ESE, 8'h20);
    ese_m = 8'h20;
    q1(ccs_pkg::CCS_CMD_ESE_Q, 8'h20);
    send(ccs_pkg::CCS_CMD_SRE, 8'h20);
    sre_m = 8'h20;
    {exe_err, dde_err, qye_err} = 3'b111;
    @(negedge clk);
    {exe_err, dde_err, qye_err} = 3'b000;
    send(ccs_pkg::CCS_CMD_BAD, 8'h00);
    esr = 8'h3C;
    repeat (3) @(negedge clk);
    chk(64'(status_summary_byte), 64'(stb_m(1'b0)));
    chk(64'(srq), 64'h1);
    q1(ccs_pkg::CCS_CMD_STB_Q, stb_m(1'b0));
    q1(ccs_pkg::CCS_CMD_STB_Q, stb_m(1'b0));
    spoll = 1'b1;
    @(negedge clk);
    chk(64'(status_summary_byte), 64'(stb_m(1'b0)));
    spoll = 1'b0;
    @(negedge clk);
    chk(64'(status_summary_byte[6]), 64'h1);
    spoll = 1'b1;
    @(negedge clk);
    chk(64'(status_summary_byte[6]), 64'h0);
    spoll = 1'b0;
    repeat (2) @(negedge clk);
    chk(64'(srq), 64'h0);
    q1(ccs_pkg::CCS_CMD_ESR_Q, 8'h3C);
    send(ccs_pkg::CCS_CMD_BAD, 8'h00);
    send(ccs_pkg::CCS_CMD_CLS, 8'h00);
    esr = 0;
    repeat (2) @(negedge clk);
    chk(64'(status_summary_byte), 64'(stb_m(1'b0)));
    chk(64'(clr_seen), 64'h1);
    q1(ccs_pkg::CCS_CMD_ESE_Q, 8'h20);
    q1(ccs_pkg::CCS_CMD_SRE_Q, 8'h20);
    // Status sources follow within one cycle
    send(ccs_pkg::CCS_CMD_SRE, 8'h8C);
    sre_m = 8'h8C;
    repeat (6) begin
      {oper_sum, ques_sum, err_pending} = 3'($urandom);
      @(negedge clk);
      chk(64'(status_summary_byte), 64'(stb_m(1'b0)));
    end
    {oper_sum, ques_sum, err_pending} = 3'b000;
    // Message available while a reply waits
    stall = 1'b1;
    send(ccs_pkg::CCS_CMD_STB_Q, 8'h00);
    repeat (4) @(negedge clk);
    chk(64'(status_summary_byte[4]), 64'h1);
    stall = 1'b0;
    get(b);
    chk(64'(b), 64'(stb_m(1'b0)));
    repeat (3) @(negedge clk);
    chk(64'(status_summary_byte[4]), 64'h0);
    // Operation complete, command and query
    out_settled = 1'b0;
    send(ccs_pkg::CCS_CMD_OPC, 8'h00);
    q1(ccs_pkg::CCS_CMD_ESR_Q, 8'h00);
    out_settled = 1'b1;
    esr = 1;
    q1(ccs_pkg::CCS_CMD_ESR_Q, 8'h01);
    esr = 0;
    out_settled = 1'b0;
    send(ccs_pkg::CCS_CMD_OPC_Q, 8'h00);
    repeat (5) @(negedge clk);
    chk(64'(cmd_ready), 64'h0);
    chk(64'(ctl.rx_q.size()), 64'h0);
    out_settled = 1'b1;
    get(b);
    chk(64'(b), 64'(ccs_pkg::CH_1));
    // Trigger: not listening, listening, continuous with group trigger
    trg(1'b0, 1'b0);
    trg(1'b1, 1'b0);
    init_cont = 1'b1;
    trg(1'b1, 1'b1);
    init_cont = 1'b0;
    // Save to edge slots and out-of-range slots, reset, recall
    foreach (sl[i]) begin
      trg(1'b1, 1'b0);
      send(ccs_pkg::CCS_CMD_SAV, 8'(sl[i]));
      if (sl[i] >= 1 && sl[i] <= 40) slot_m[sl[i]] = lv_m;
    end
    send(ccs_pkg::CCS_CMD_RST, 8'h00);
    lv_m = {ccs_pkg::LVL_ZERO, ccs_pkg::LVL_ZERO, ccs_pkg::LVL_MAX, ccs_pkg::LVL_MAX};
    repeat (2) @(negedge clk);
    chk(setting[65:2], lv_m);
    chk(64'(setting.outp_on), 64'h1);
    foreach (rc[i]) begin
      send(ccs_pkg::CCS_CMD_RCL, 8'(rc[i]));
      repeat (3) @(negedge clk);
      if (rc[i] >= 1 && rc[i] <= 40) lv_m = slot_m[rc[i]];
      chk(setting[65:2], lv_m);
    end
    // Self test pass and fail
    nv_crc_ref = crc_m();
    q1(ccs_pkg::CCS_CMD_TST_Q, ccs_pkg::CH_0);
    nv_crc_ref = nv_crc_ref ^ 8'h01;
    q1(ccs_pkg::CCS_CMD_TST_Q, ccs_pkg::CH_1);
    // Identification string
    send(ccs_pkg::CCS_CMD_IDN_Q, 8'h00);
    foreach (idn[i]) begin
      get(b);
      chk(64'(b), 64'(idn[i]));
    end
    print_verdict();
  end
endmodule : tb
